// ### design/ufa_endpoint_fifo_regs.svh
// Purpose: Offsets, field positions and reset values of the endpoint FIFO access block.
// Assumes: Byte addresses on the parallel register port, 16-bit data.
// Notes: Overview of operation follows.
// Overview of operation
// - Data port reaches indexed endpoint FIFO.
// - IN write advances pointer by two or one.
// - IN buffer validated when count reaches packet size.
// - OUT read steps pointer by two or one.
// - OUT buffer freed once fully read.
// - Validate bit sends a short IN buffer.
// - Clear bit discards the indexed RX buffer.
// - Buffer length holds 16-bit packet byte count.
// - Packet size write reloads every buffer length.
// - USB bus reset zeroes buffer length.
// - Programmed length triggers automatic validate of IN buffers only.
// - Acknowledged OUT packet loads received byte count.
// - Odd final byte appears on low lane.
// - Read-only 2-bit double buffer fill status.
// - Status 00 none, 01 one, 11 both.
// - Packet size register ignores control endpoint zero.
// - Transactions field selects one to three packets.
// - 11-bit field sets FIFO size in bytes.
// - Sizes 8 to 512; iso 3x400h gives 3072.
// - Index register selects endpoint and direction.
`ifndef UFA_ENDPOINT_FIFO_REGS_SVH
`define UFA_ENDPOINT_FIFO_REGS_SVH

`define UFA_OFS_MPS     8'h04
`define UFA_OFS_TYPE    8'h08
`define UFA_OFS_BLEN    8'h1c
`define UFA_OFS_BSTAT   8'h1e
`define UFA_OFS_DATA    8'h20
`define UFA_OFS_CTRL    8'h28
`define UFA_OFS_INDEX   8'h2a

`define UFA_CTRL_CLEAR  4
`define UFA_CTRL_VALID  3
`define UFA_TYPE_DBL    2
`define UFA_IDX_DIR     0
`define UFA_SIZE_HI     10
`define UFA_NTR_LO      11
`define UFA_NTR_HI      12

`define UFA_RST_MPS     16'h0000
`define UFA_RST_BLEN    16'h0000
`define UFA_BANK_BYTES  11'h200
`define UFA_ISO_SIZE    11'h400

`endif

// ### design/ufa_pkg.sv
// Purpose: Types shared by the endpoint FIFO access block.
// Assumes: Nothing beyond the register header.
// Notes: Constants live in the register header.
package ufa_pkg;

    typedef logic [10:0] ufa_ptr_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic        rd;
        logic        byte_mode;
        logic [15:0] wdata;
    } ufa_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
        logic       zlp;
    } ufa_beat_t;

    typedef enum logic [2:0] {
        UFA_TX_IDLE = 3'b001,
        UFA_TX_SEND = 3'b010,
        UFA_TX_DONE = 3'b100
    } ufa_tx_state_t;

endpackage

// ### design/ufa_byte_ram.sv
// Purpose: Byte-wide FIFO storage with a word write port and a word read port.
// Assumes: Read is combinational; the reader registers what it needs.
// Notes: No reset; contents are only read behind a valid byte count.
`timescale 1ns/1ns
module ufa_byte_ram (
    input  wire logic        ref_clk,
    input  wire logic        we_lo,
    input  wire logic        we_hi,
    input  wire logic [12:0] waddr,
    input  wire logic [15:0] wdata,
    input  wire logic [12:0] raddr,
    output logic      [15:0] rdata
);
    logic [7:0] mem [0:8191];

    always_ff @(posedge ref_clk) begin
        if (we_lo) begin
            mem[waddr] <= wdata[7:0];
        end
        if (we_hi) begin
            mem[waddr + 13'h0001] <= wdata[15:8];
        end
    end

    assign rdata = {mem[raddr + 13'h0001], mem[raddr]};
endmodule

// ### design/ufa_pair_buf.sv
// Purpose: Two-entry buffer on the transmit byte stream.
// Assumes: Source pushes only while in_ready is high.
// Notes: Two entries let the source push every cycle while the sink is ready, and hold one extra beat while it stalls.
`timescale 1ns/1ns
module ufa_pair_buf (
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    input  wire logic              flush,
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  ufa_pkg::ufa_beat_t     in_beat,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output ufa_pkg::ufa_beat_t     out_beat
);
    ufa_pkg::ufa_beat_t e1;
    logic [1:0]         cnt;
    logic               push;
    logic               pop;

    assign in_ready  = (cnt != 2'h2);
    assign out_valid = (cnt != 2'h0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt      <= 2'h0;
            out_beat <= '0;
            e1       <= '0;
        end else if (flush) begin
            cnt <= 2'h0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (cnt == 2'h0) out_beat <= in_beat;
                    else e1 <= in_beat;
                    cnt <= cnt + 2'h1;
                end
                2'b01: begin
                    out_beat <= e1;
                    cnt      <= cnt - 2'h1;
                end
                2'b11: begin
                    if (cnt == 2'h1) begin
                        out_beat <= in_beat;
                    end else begin
                        out_beat <= e1;
                        e1       <= in_beat;
                    end
                end
                default: begin
                    cnt <= cnt;
                end
            endcase
        end
    end
endmodule

// ### design/ufa_endpoint_fifo.sv
// Purpose: Endpoint FIFO access, validate and clear, and sizing for the parallel register port.
// Assumes: Requests synchronous to ref_clk; one request per cycle at most.
// Notes: Each endpoint bank holds 512 bytes; larger isochronous sizes are reported, not stored.
`timescale 1ns/1ns
`include "ufa_endpoint_fifo_regs.svh"
module ufa_endpoint_fifo (
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    input  ufa_pkg::ufa_req_t      host_req,
    output logic [15:0]            host_rdata,
    output logic                   host_rvalid,
    input  wire logic              usb_bus_reset,
    input  wire logic [2:0]        rx_ep,
    input  wire logic              rx_valid,
    output logic                   rx_ready,
    input  wire logic [7:0]        rx_data,
    input  wire logic              rx_ack,
    input  wire logic [2:0]        tx_ep,
    input  wire logic              in_token,
    output logic                   tx_nak,
    output logic                   tx_valid,
    input  wire logic              tx_ready,
    output ufa_pkg::ufa_beat_t     tx_beat,
    output logic [12:0]            alloc_bytes,
    output logic                   size_supported
);
    logic [2:0]         endpoint_select;
    logic               dir;
    logic [15:0]        mps [0:15];
    logic [15:0]        blen [0:15];
    logic               dbl [0:15];
    ufa_pkg::ufa_ptr_t  wr_ptr [0:15];
    ufa_pkg::ufa_ptr_t  rd_ptr [0:15];
    logic [15:0]        pk_len [0:15][0:1];
    logic               wbank [0:15];
    logic               rbank [0:15];
    logic [1:0]         fill [0:15];

    function automatic logic [1:0] ufa_nbuf(input logic d);
        ufa_nbuf = d ? 2'h2 : 2'h1;
    endfunction

    function automatic logic [15:0] ufa_step(input logic bm, input logic [15:0] rem);
        if (rem == 16'h0000) ufa_step = 16'h0000;
        else if (bm || rem == 16'h0001) ufa_step = 16'h0001;
        else ufa_step = 16'h0002;
    endfunction

    function automatic logic [15:0] ufa_thr(input logic [10:0] sz, input logic [15:0] bl);
        if (bl != 16'h0000 && bl < {5'h00, sz}) ufa_thr = bl;
        else ufa_thr = {5'h00, sz};
    endfunction

    // CPU side decode.
    logic [3:0]         cs;
    logic               a_data;
    logic               a_ctrl;
    logic               cpu_tx_wr;
    ufa_pkg::ufa_ptr_t  step_w;
    ufa_pkg::ufa_ptr_t  new_wp;
    logic [15:0]        thr;
    logic               auto_val;
    logic               force_validate;
    logic               validate;
    logic [15:0]        val_len;
    logic [15:0]        rx_rem;
    logic [15:0]        rd_step;
    logic [15:0]        rx_next;
    logic               cpu_rx_rd;
    logic               force_clear;
    logic               cpu_release;
    logic [15:0]        ram_rx_word;

    assign cs        = {endpoint_select, dir};
    assign a_data    = (host_req.addr == `UFA_OFS_DATA);
    assign a_ctrl    = host_req.wr && (host_req.addr == `UFA_OFS_CTRL);
    assign cpu_tx_wr = host_req.wr && a_data && dir && (fill[cs] < ufa_nbuf(dbl[cs]));
    assign step_w    = host_req.byte_mode ? 11'h001 : 11'h002;
    assign new_wp    = wr_ptr[cs] + step_w;
    assign thr       = ufa_thr(mps[cs][`UFA_SIZE_HI:0], blen[cs]);
    assign auto_val  = cpu_tx_wr && (thr != 16'h0000) && ({5'h00, new_wp} >= thr);
    assign force_validate = a_ctrl && host_req.wdata[`UFA_CTRL_VALID] && dir
                            && (fill[cs] < ufa_nbuf(dbl[cs]));
    assign validate  = auto_val || force_validate;
    assign val_len   = auto_val ? {5'h00, new_wp} : {5'h00, wr_ptr[cs]};
    assign rx_rem    = pk_len[cs][rbank[cs]];
    assign rd_step   = ufa_step(host_req.byte_mode, rx_rem);
    assign rx_next   = rx_rem - rd_step;
    assign cpu_rx_rd = host_req.rd && a_data && !dir && (fill[cs] != 2'h0);
    assign force_clear = a_ctrl && host_req.wdata[`UFA_CTRL_CLEAR] && !dir && (fill[cs] != 2'h0);
    assign cpu_release = (cpu_rx_rd && rx_next == 16'h0000) || force_clear;

    // USB receive side.
    logic [3:0]         us;
    logic               rx_take;
    logic               ack_ok;
    ufa_pkg::ufa_ptr_t  rx_cnt;

    assign us       = {rx_ep, 1'b0};
    assign rx_ready = (fill[us] < ufa_nbuf(dbl[us])) && (wr_ptr[us] < `UFA_BANK_BYTES);
    assign rx_take  = rx_valid && rx_ready;
    assign rx_cnt   = wr_ptr[us] + {10'h000, rx_take};
    assign ack_ok   = rx_ack && (fill[us] < ufa_nbuf(dbl[us]));

    // USB transmit side.
    ufa_pkg::ufa_tx_state_t tx_state;
    logic [3:0]         tx_slot;
    logic               tx_bank;
    logic [15:0]        tx_len;
    logic [15:0]        tx_cnt;
    logic               tx_release;
    logic               buf_ready;
    logic               push;
    ufa_pkg::ufa_beat_t push_beat;
    logic [15:0]        ram_tx_word;
    logic [3:0]         ts;

    assign ts              = {tx_ep, 1'b1};
    assign tx_release      = (tx_state == ufa_pkg::UFA_TX_DONE);
    assign push            = (tx_state == ufa_pkg::UFA_TX_SEND) && buf_ready;
    assign push_beat.data  = (tx_len == 16'h0000) ? 8'h00 : ram_tx_word[7:0];
    assign push_beat.zlp   = (tx_len == 16'h0000);
    assign push_beat.last  = (tx_len == 16'h0000) || (tx_cnt + 16'h0001 == tx_len);

    ufa_byte_ram u_rx_ram (
        .ref_clk (ref_clk),
        .we_lo   (rx_take),
        .we_hi   (1'b0),
        .waddr   ({rx_ep, wbank[us], wr_ptr[us][8:0]}),
        .wdata   ({8'h00, rx_data}),
        .raddr   ({endpoint_select, rbank[cs], rd_ptr[cs][8:0]}),
        .rdata   (ram_rx_word)
    );

    ufa_byte_ram u_tx_ram (
        .ref_clk (ref_clk),
        .we_lo   (cpu_tx_wr),
        .we_hi   (cpu_tx_wr && !host_req.byte_mode),
        .waddr   ({endpoint_select, wbank[cs], wr_ptr[cs][8:0]}),
        .wdata   (host_req.wdata),
        .raddr   ({tx_slot[3:1], tx_bank, tx_cnt[8:0]}),
        .rdata   (ram_tx_word)
    );

    ufa_pair_buf u_tx_buf (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .flush     (usb_bus_reset),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .in_beat   (push_beat),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_beat  (tx_beat)
    );

    // Configuration registers.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            endpoint_select <= 3'h0;
            dir             <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                mps[i]  <= `UFA_RST_MPS;
                blen[i] <= `UFA_RST_BLEN;
                dbl[i]  <= 1'b0;
            end
        end else if (usb_bus_reset) begin
            endpoint_select <= 3'h0;
            dir             <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                mps[i]  <= `UFA_RST_MPS;
                blen[i] <= `UFA_RST_BLEN;
                dbl[i]  <= 1'b0;
            end
        end else if (host_req.wr) begin
            case (host_req.addr)
                `UFA_OFS_INDEX: begin
                    endpoint_select <= host_req.wdata[3:1];
                    dir             <= host_req.wdata[`UFA_IDX_DIR];
                end
                `UFA_OFS_MPS: begin
                    if (endpoint_select != 3'h0) begin
                        mps[cs] <= {3'h0, host_req.wdata[12:0]};
                        for (int i = 0; i < 16; i++) begin
                            blen[i] <= {5'h00, host_req.wdata[`UFA_SIZE_HI:0]};
                        end
                    end
                end
                `UFA_OFS_BLEN: begin
                    blen[cs] <= host_req.wdata;
                end
                `UFA_OFS_TYPE: begin
                    dbl[cs] <= host_req.wdata[`UFA_TYPE_DBL];
                end
                default: begin
                    dir <= dir;
                end
            endcase
        end
    end

    // Per endpoint and direction buffer state; increments and decrements of the fill
    // count are summed so that an event in the same cycle as a release is never lost.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 16; i++) begin
                fill[i]      <= 2'h0;
                wbank[i]     <= 1'b0;
                rbank[i]     <= 1'b0;
                wr_ptr[i]    <= 11'h000;
                rd_ptr[i]    <= 11'h000;
                pk_len[i][0] <= 16'h0000;
                pk_len[i][1] <= 16'h0000;
            end
        end else if (usb_bus_reset) begin
            for (int i = 0; i < 16; i++) begin
                fill[i]      <= 2'h0;
                wbank[i]     <= 1'b0;
                rbank[i]     <= 1'b0;
                wr_ptr[i]    <= 11'h000;
                rd_ptr[i]    <= 11'h000;
                pk_len[i][0] <= 16'h0000;
                pk_len[i][1] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 16; i++) begin
                fill[i] <= fill[i]
                           + {1'b0, (validate && cs == 4'(i)) || (ack_ok && us == 4'(i))}
                           - {1'b0, (cpu_release && cs == 4'(i)) || (tx_release && tx_slot == 4'(i))};
            end
            if (cpu_tx_wr) begin
                wr_ptr[cs] <= new_wp;
            end
            if (validate) begin
                pk_len[cs][wbank[cs]] <= val_len;
                wbank[cs]             <= wbank[cs] ^ dbl[cs];
                wr_ptr[cs]            <= 11'h000;
            end
            if (cpu_rx_rd) begin
                pk_len[cs][rbank[cs]] <= rx_next;
                rd_ptr[cs]            <= rd_ptr[cs] + rd_step[10:0];
            end
            if (cpu_release) begin
                pk_len[cs][rbank[cs]] <= 16'h0000;
                rbank[cs]             <= rbank[cs] ^ dbl[cs];
                rd_ptr[cs]            <= 11'h000;
            end
            if (rx_take) begin
                wr_ptr[us] <= rx_cnt;
            end
            if (ack_ok) begin
                pk_len[us][wbank[us]] <= {5'h00, rx_cnt};
                wbank[us]             <= wbank[us] ^ dbl[us];
                wr_ptr[us]            <= 11'h000;
            end
            if (tx_release) begin
                rbank[tx_slot] <= rbank[tx_slot] ^ dbl[tx_slot];
            end
        end
    end

    // Transmit sequencer; a token that finds no validated buffer is answered with a NAK pulse.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_state <= ufa_pkg::UFA_TX_IDLE;
            tx_slot  <= 4'h1;
            tx_bank  <= 1'b0;
            tx_len   <= 16'h0000;
            tx_cnt   <= 16'h0000;
            tx_nak   <= 1'b0;
        end else if (usb_bus_reset) begin
            tx_state <= ufa_pkg::UFA_TX_IDLE;
            tx_nak   <= 1'b0;
        end else begin
            tx_nak <= 1'b0;
            case (tx_state)
                ufa_pkg::UFA_TX_IDLE: begin
                    if (in_token && fill[ts] != 2'h0) begin
                        tx_slot  <= ts;
                        tx_bank  <= rbank[ts];
                        tx_len   <= pk_len[ts][rbank[ts]];
                        tx_cnt   <= 16'h0000;
                        tx_state <= ufa_pkg::UFA_TX_SEND;
                    end else if (in_token) begin
                        tx_nak <= 1'b1;
                    end
                end
                ufa_pkg::UFA_TX_SEND: begin
                    if (push) begin
                        tx_cnt <= tx_cnt + 16'h0001;
                        if (push_beat.last) begin
                            tx_state <= ufa_pkg::UFA_TX_DONE;
                        end
                    end
                end
                ufa_pkg::UFA_TX_DONE: begin
                    tx_state <= ufa_pkg::UFA_TX_IDLE;
                end
                default: begin
                    tx_state <= ufa_pkg::UFA_TX_IDLE;
                end
            endcase
        end
    end

    // Register reads are answered one cycle after the strobe.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            host_rdata  <= 16'h0000;
            host_rvalid <= 1'b0;
        end else begin
            host_rvalid <= host_req.rd;
            if (host_req.rd) begin
                case (host_req.addr)
                    `UFA_OFS_INDEX: host_rdata <= {12'h000, endpoint_select, dir};
                    `UFA_OFS_MPS:   host_rdata <= mps[cs];
                    `UFA_OFS_TYPE:  host_rdata <= {13'h0000, dbl[cs], 2'h0};
                    `UFA_OFS_BLEN:  host_rdata <= dir ? blen[cs] : rx_rem;
                    `UFA_OFS_BSTAT: begin
                        // Endpoint zero has no status; the field is zero there.
                        if (endpoint_select == 3'h0) host_rdata <= 16'h0000;
                        else host_rdata <= {14'h0000, fill[cs] == 2'h2, fill[cs] != 2'h0};
                    end
                    `UFA_OFS_DATA: begin
                        if (!cpu_rx_rd) host_rdata <= 16'h0000;
                        else if (rd_step == 16'h0001) host_rdata <= {8'h00, ram_rx_word[7:0]};
                        else host_rdata <= ram_rx_word;
                    end
                    default: host_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // Allocation of the indexed endpoint, from size and transactions per microframe.
    logic [1:0]  ntr;
    logic [10:0] fsz;
    assign ntr = mps[cs][`UFA_NTR_HI:`UFA_NTR_LO];
    assign fsz = mps[cs][`UFA_SIZE_HI:0];
    always_comb begin
        alloc_bytes    = 13'h0000;
        size_supported = 1'b0;
        if (ntr != 2'h3) begin
            alloc_bytes = 13'({2'h0, fsz} * ({11'h000, ntr} + 13'h0001));
        end
        if (ntr == 2'h0 && fsz >= 11'h008 && fsz <= `UFA_BANK_BYTES && (fsz & (fsz - 11'h001)) == 11'h000) begin
            size_supported = 1'b1;
        end
        if (ntr == 2'h2 && fsz == `UFA_ISO_SIZE) begin
            size_supported = 1'b1;
        end
    end
endmodule

// ### testbench/ufa_fifo_monitor.sv
// Purpose: Port assertions of the endpoint FIFO block.
// Assumes: One clock, arst_n active low.
// Notes: Only behaviour visible at the ports is judged, so internal retiming stays free.
`timescale 1ns/1ns
module ufa_fifo_monitor (
    input wire logic          ref_clk,
    input wire logic          arst_n,
    input ufa_pkg::ufa_req_t  host_req,
    input wire logic [15:0]   host_rdata,
    input wire logic          host_rvalid,
    input wire logic          usb_bus_reset,
    input wire logic          in_token,
    input wire logic          tx_nak,
    input wire logic          tx_valid,
    input wire logic          tx_ready,
    input ufa_pkg::ufa_beat_t tx_beat,
    input wire logic [12:0]   alloc_bytes,
    input wire logic          size_supported
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    read_answer_a: assert property (host_req.rd |=> host_rvalid) else $error("no answer");
    answer_cause_a: assert property (host_rvalid |-> $past(host_req.rd)) else $error("stray answer");
    answer_pulse_a: assert property (host_rvalid && !host_req.rd |=> !host_rvalid) else $error("long answer");
    data_hold_a: assert property (!host_req.rd |=> $stable(host_rdata)) else $error("data moved");
    nak_cause_a: assert property (tx_nak |-> $past(in_token)) else $error("stray nak");
    beat_hold_a: assert property (tx_valid && !tx_ready && !usb_bus_reset |=> tx_valid && $stable(tx_beat))
        else $error("beat dropped");
    empty_beat_a: assert property (tx_valid && tx_beat.zlp |-> tx_beat.last && tx_beat.data == 8'h00)
        else $error("bad empty packet");
    fifo_alloc_a: assert property (size_supported |-> alloc_bytes inside {13'h8, 13'h10, 13'h20, 13'h40,
        13'h80, 13'h100, 13'h200, 13'hc00}) else $error("bad allocation");
    stall_c: cover property (tx_valid && !tx_ready);
    empty_c: cover property (tx_valid && tx_ready && tx_beat.zlp);
    nak_c: cover property (tx_nak);
endmodule
bind ufa_endpoint_fifo ufa_fifo_monitor u_ufa_fifo_monitor (.ref_clk, .arst_n, .host_req, .host_rdata,
    .host_rvalid, .usb_bus_reset, .in_token, .tx_nak, .tx_valid, .tx_ready, .tx_beat, .alloc_bytes, .size_supported);

// ### testbench/ufa_usb_host.sv
// Purpose: Behavioural USB host traffic for the endpoint FIFO block.
// Assumes: The bench calls its tasks; traffic is on endpoint one.
// Notes: Ready drops one cycle in four so the transmit buffer must hold beats.
`timescale 1ns/1ns
module ufa_usb_host (
    input  wire logic          ref_clk,
    output logic               rx_valid,
    input  wire logic          rx_ready,
    output logic [7:0]         rx_data,
    output logic               rx_ack,
    output logic               in_token,
    input  wire logic          tx_nak,
    input  wire logic          tx_valid,
    output logic               tx_ready,
    input  ufa_pkg::ufa_beat_t tx_beat
);
    logic [15:0] got[$];
    logic [1:0]  cnt = 2'h0;
    int          naks = 0;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_ack = 1'b0;
        in_token = 1'b0;
        tx_ready = 1'b1;
    end
    always @(posedge ref_clk) begin
        cnt <= cnt + 2'h1;
        tx_ready <= cnt != 2'h3;
        if (tx_valid && tx_ready) got.push_back({6'h00, tx_beat});
        if (tx_nak) naks++;
    end
    task automatic send_out(input int n);
        int i;
        i = 0;
        rx_valid <= 1'b1;
        while (i < n) begin
            rx_data <= 8'ha0 + 8'(i);
            @(posedge ref_clk);
            if (rx_ready) i++;
        end
        rx_valid <= 1'b0;
        rx_ack <= 1'b1;
        @(posedge ref_clk);
        rx_ack <= 1'b0;
    endtask
    task automatic token;
        in_token <= 1'b1;
        @(posedge ref_clk);
        in_token <= 1'b0;
    endtask
endmodule

// ### testbench/usb_endpoint_fifo_access_test.sv
// Purpose: Self-checking bench of the endpoint FIFO access block.
// Assumes: USB traffic comes from the partner model on endpoint one.
// Notes: Each scenario task drives and judges its own traffic.
`timescale 1ns/1ns
`include "ufa_endpoint_fifo_regs.svh"
module usb_endpoint_fifo_access_test;
    logic               ref_clk = 1'b0;
    logic               arst_n = 1'b0;
    logic               usb_bus_reset = 1'b0;
    ufa_pkg::ufa_req_t  host_req = '0;
    ufa_pkg::ufa_beat_t tx_beat;
    logic [15:0]        host_rdata;
    logic [12:0]        alloc_bytes;
    logic [7:0]         rx_data;
    logic               host_rvalid, rx_valid, rx_ready, rx_ack, in_token, tx_nak, tx_valid, tx_ready, size_supported;
    int                 num_errors = 0;
    int                 num_checks = 0;
    logic [16:0]        seen;
    always #2 ref_clk = ~ref_clk;
    ufa_endpoint_fifo u_ufa_endpoint_fifo (.ref_clk, .arst_n, .host_req, .host_rdata, .host_rvalid, .usb_bus_reset,
        .rx_ep(3'h1), .rx_valid, .rx_ready, .rx_data, .rx_ack, .tx_ep(3'h1), .in_token, .tx_nak, .tx_valid, .tx_ready,
        .tx_beat, .alloc_bytes, .size_supported);
    ufa_usb_host u_ufa_usb_host (.ref_clk, .rx_valid, .rx_ready, .rx_data, .rx_ack, .in_token, .tx_nak, .tx_valid,
        .tx_ready, .tx_beat);
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) num_errors++;
        if (g !== e) $display("wrong value %s expected %h seen %h", n, e, g);
    endtask
    task automatic acc(input logic [7:0] a, input logic [15:0] d, input logic w = 1'b1, input logic b = 1'b0);
        host_req <= '{a, w, !w, b, d};
        @(posedge ref_clk);
        host_req.wr <= 1'b0;
        host_req.rd <= 1'b0;
        @(negedge ref_clk);
        seen = {host_rvalid, host_rdata};
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic b = 1'b0);
        acc(a, 16'h0000, 1'b0, b);
        chk($sformatf("register %h", a), e, seen[16] ? seen[15:0] : 16'hdead);
    endtask
    task automatic beats(input int n, input logic [7:0] b, input logic z = 1'b0);
        for (int k = 0; k < 99 && u_ufa_usb_host.got.size() < n; k++) @(posedge ref_clk);
        for (int i = 0; i < n; i++) chk("beat", {6'h00, b + 8'(i), i == n - 1, z}, u_ufa_usb_host.got[i]);
        u_ufa_usb_host.got.delete();
    endtask
    task automatic t_in;
        acc(`UFA_OFS_INDEX, 16'h0003);
        acc(`UFA_OFS_MPS, 16'h0004);
        rd(`UFA_OFS_BLEN, 16'h0004);
        acc(`UFA_OFS_DATA, 16'h0201);
        acc(`UFA_OFS_DATA, 16'h0403);
        rd(`UFA_OFS_BSTAT, 16'h0001);
        u_ufa_usb_host.token();
        beats(4, 8'h01);
        acc(`UFA_OFS_BLEN, 16'h0003);
        acc(`UFA_OFS_DATA, 16'h0605);
        acc(`UFA_OFS_DATA, 16'hee07, 1'b1, 1'b1);
        u_ufa_usb_host.token();
        beats(3, 8'h05);
        acc(`UFA_OFS_CTRL, 16'h0008);
        u_ufa_usb_host.token();
        beats(1, 8'h00, 1'b1);
        @(posedge ref_clk);
        u_ufa_usb_host.token();
        repeat (2) @(posedge ref_clk);
        chk("nak count", 16'h0001, 16'(u_ufa_usb_host.naks));
    endtask
    task automatic t_out;
        acc(`UFA_OFS_INDEX, 16'h0002);
        u_ufa_usb_host.send_out(3);
        rd(`UFA_OFS_BLEN, 16'h0003);
        chk("rx ready", 16'h0000, 16'(rx_ready));
        rd(`UFA_OFS_DATA, 16'ha1a0);
        rd(`UFA_OFS_DATA, 16'h00a2);
        rd(`UFA_OFS_BSTAT, 16'h0000);
        u_ufa_usb_host.send_out(2);
        rd(`UFA_OFS_DATA, 16'h00a0, 1'b1);
        rd(`UFA_OFS_BLEN, 16'h0001);
        acc(`UFA_OFS_CTRL, 16'h0010);
        rd(`UFA_OFS_BSTAT, 16'h0000);
        acc(`UFA_OFS_TYPE, 16'h0004);
        repeat (2) u_ufa_usb_host.send_out(1);
        rd(`UFA_OFS_BSTAT, 16'h0003);
        rd(`UFA_OFS_DATA, 16'h00a0);
        rd(`UFA_OFS_BSTAT, 16'h0001);
    endtask
    task automatic t_size;
        logic [15:0] m[6] = '{16'h0008, 16'h0200, 16'h0003, 16'h1400, 16'h0840, 16'h1840};
        logic [15:0] a[6] = '{16'h8008, 16'h8200, 16'h0003, 16'h8c00, 16'h0080, 16'h0000};
        acc(`UFA_OFS_INDEX, 16'h0003);
        foreach (m[i]) begin
            acc(`UFA_OFS_MPS, m[i]);
            rd(`UFA_OFS_BLEN, {5'h00, m[i][10:0]});
            chk("allocation", a[i], {size_supported, 2'h0, alloc_bytes});
        end
        usb_bus_reset <= 1'b1;
        @(posedge ref_clk);
        usb_bus_reset <= 1'b0;
        acc(`UFA_OFS_INDEX, 16'h0003);
        rd(`UFA_OFS_BLEN, 16'h0000);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(`UFA_OFS_BLEN, 16'h0000);
        rd(`UFA_OFS_BSTAT, 16'h0000);
        rd(8'h3e, 16'h0000);
        acc(`UFA_OFS_MPS, 16'h0040);
        rd(`UFA_OFS_MPS, 16'h0000);
        t_in;
        t_out;
        t_size;
        print_verdict;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        print_verdict;
    end
endmodule
